// ### core/ctm_defines.svh
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CTM_OFS_CTRL0 5'h00
`define CTM_OFS_CTRL1 5'h04
`define CTM_OFS_CMPA 5'h08
`define CTM_OFS_COUNT 5'h0C
`define CTM_OFS_FLAGS 5'h10
`define CTM_OFS_PRESC 5'h14

// ****************************************
// field positions
// ****************************************
// timer_control_zero
`define CTM_C0_PAUSE 7
`define CTM_C0_RUN 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0
// timer_control_one
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_ACT_HI 5
`define CTM_C1_ACT_LO 4
`define CTM_C1_INIT 3
`define CTM_C1_INV 2
`define CTM_C1_SWAP 1
`define CTM_C1_CLRSEL 0
// flag register, write one to clear
`define CTM_FL_A 0
`define CTM_FL_P 1

// ****************************************
// reset values and counts
// ****************************************
`define CTM_RST_BYTE 8'h00
`define CTM_RST_CMPA 10'h000
`define CTM_RST_FLAGS 2'h0
`define CTM_RST_CNT 10'h000
`define CTM_PER_LSB 7'h00
`define CTM_FULL_SPAN 11'h400
`define CTM_CNT_ONE 11'h001
`define CTM_BUS_IDLE 32'h0000_0000

`endif

// ### core/ctm_pkg.sv
package ctm_pkg;

   // operating modes from the two-bit mode field
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'h0,
      CTM_MODE_UNDEF = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TMR = 2'h3
   } ctm_mode_e;

   // output_action in compare-match output mode
   typedef enum logic [1:0] {
      CTM_ACT_NONE = 2'h0,
      CTM_ACT_LOW = 2'h1,
      CTM_ACT_HIGH = 2'h2,
      CTM_ACT_TOGGLE = 2'h3
   } ctm_cmp_act_e;

   // output_action in pwm mode
   typedef enum logic [1:0] {
      CTM_PWM_INACTIVE = 2'h0,
      CTM_PWM_ACTIVE = 2'h1,
      CTM_PWM_RUN = 2'h2,
      CTM_PWM_UNDEF = 2'h3
   } ctm_pwm_act_e;

endpackage

// ### core/ctm_timer.sv
// Contract
// R1 - mode 00 is compare-match output mode
// R2 - clear_select low: period match or overflow clears
// R3 - clear_select low: both flags raised
// R4 - clear_select high: compare-A clears, A flag only
// R5 - compare-A zero: overflow at 3FF, no flag
// R6 - pin changes only on compare-A flag
// R7 - output_action picks none, low, high, toggle
// R8 - run rising edge loads initial pin level
// R9 - mode 11 counts alike, pin unused
// R10 - mode 10 generates pwm on the pin
// R11 - pwm ignores clear_select
// R12 - swap zero: period code sets period
// R13 - period code times 128, zero is 1024
// R14 - swap one: compare-A sets period
// R15 - duty at or above period gives 100%
// R16 - pwm raises both flags on matches
// R17 - initial level polarity, action forces pin
// R18 - output_invert inverts the driven waveform
// R19 - forced pin keeps pwm counting running
// R20 - run rise zeroes counter, fall holds
// R21 - period code compared with bits 9..7
// R22 - action 00 none, 01 low, 10 high, 11 toggle
// R23 - pause freezes counter, resume from value
// R24 - count up per tick, wrap after clear
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "ctm_defines.svh"

module ctm_timer
   import ctm_pkg::*;
#(
   parameter int CNT_W = 10, // counter width
   parameter int PRESC_W = 8 // tick divider width
) (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic TIMER_OUT,
   output logic TIMER_OUT_EN,
   output logic COMPARE_A_FLAG,
   output logic PERIOD_MATCH_FLAG
);

   // ****************************************
   // elaboration checks
   // ****************************************
   // the period code and the 3FF overflow assume ten bits
   if (CNT_W != 10) begin : g_bad_width
      $error("ctm_timer: CNT_W must be 10");
   end
   if (PRESC_W < 1 || PRESC_W > 8) begin : g_bad_presc
      $error("ctm_timer: PRESC_W must be 1 to 8");
   end

   // ****************************************
   // byte lane merge
   // ****************************************
   // keeps old bits where the lane is not enabled
   function automatic logic [7:0] ctm_merge(
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic en
   );
      ctm_merge = en ? new_v : old_v;
   endfunction

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta_r; // first stage, read by second only
   logic rst_n_sync; // released reset for the rest

   // async assert, clocked release
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_r <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_sync <= rst_meta_r;
      end
   end

   // ****************************************
   // register storage
   // ****************************************
   logic [7:0] ctrl0_r; // pause, run, period code
   logic [7:0] ctrl1_r; // mode, action, level, swap
   logic [9:0] cmpa_r; // compare_a_value
   logic [7:0] presc_r; // tick divider
   logic [1:0] flag_r; // sticky match flags
   logic [9:0] cnt_r; // the up-counter
   logic wreq_r; // waitrequest flop
   logic [31:0] rdata_r; // captured read data
   logic [31:0] rd_nxt; // read mux result
   logic wr_go; // write completes this edge
   logic rd_go; // read captured this edge

   // ****************************************
   // field views
   // ****************************************
   logic counter_pause;
   logic counter_run;
   logic [2:0] period_compare_value;
   ctm_mode_e mode;
   logic [1:0] output_action;
   logic output_initial_level;
   logic output_invert;
   logic period_duty_swap;
   logic clear_select;

   assign counter_pause = ctrl0_r[`CTM_C0_PAUSE];
   assign counter_run = ctrl0_r[`CTM_C0_RUN];
   assign period_compare_value =
      ctrl0_r[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
   // R1 - mode field decode
   assign mode = ctm_mode_e'(ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
   assign output_action = ctrl1_r[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
   assign output_initial_level = ctrl1_r[`CTM_C1_INIT];
   assign output_invert = ctrl1_r[`CTM_C1_INV];
   assign period_duty_swap = ctrl1_r[`CTM_C1_SWAP];
   assign clear_select = ctrl1_r[`CTM_C1_CLRSEL];

   // ****************************************
   // avalon slave handshake
   // ****************************************
   // one wait cycle per access: the read mux is registered
   // so the answer never rides a long combinational path
   assign rd_go = AVS_READ & wreq_r;
   assign wr_go = AVS_WRITE & ~wreq_r;

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wreq_r <= 1'b1;
      end else if (!wreq_r) begin
         // answer given, back to waiting
         wreq_r <= 1'b1;
      end else if (AVS_READ || AVS_WRITE) begin
         wreq_r <= 1'b0;
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      rd_nxt = `CTM_BUS_IDLE;
      if (AVS_ADDRESS == `CTM_OFS_CTRL0) begin
         rd_nxt[7:0] = ctrl0_r;
      end else if (AVS_ADDRESS == `CTM_OFS_CTRL1) begin
         rd_nxt[7:0] = ctrl1_r;
      end else if (AVS_ADDRESS == `CTM_OFS_CMPA) begin
         rd_nxt[9:0] = cmpa_r;
      end else if (AVS_ADDRESS == `CTM_OFS_COUNT) begin
         // live counter value
         rd_nxt[9:0] = cnt_r;
      end else if (AVS_ADDRESS == `CTM_OFS_FLAGS) begin
         rd_nxt[1:0] = flag_r;
      end else if (AVS_ADDRESS == `CTM_OFS_PRESC) begin
         rd_nxt[7:0] = presc_r;
      end
   end

   // read data held until the next read is captured
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_r <= `CTM_BUS_IDLE;
      end else if (rd_go) begin
         rdata_r <= rd_nxt;
      end
   end

   assign AVS_READDATA = rdata_r;
   assign AVS_WAITREQUEST = wreq_r;

   // ****************************************
   // control register writes
   // ****************************************
   // mode and action should only change while stopped;
   // the logic does not block it, mid-run changes just
   // take effect from the next clock edge
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ctrl0_r <= `CTM_RST_BYTE;
         ctrl1_r <= `CTM_RST_BYTE;
         cmpa_r <= `CTM_RST_CMPA;
         presc_r <= `CTM_RST_BYTE;
      end else if (wr_go) begin
         if (AVS_ADDRESS == `CTM_OFS_CTRL0) begin
            ctrl0_r <= ctm_merge(ctrl0_r, AVS_WRITEDATA[7:0],
               AVS_BYTEENABLE[0]);
         end else if (AVS_ADDRESS == `CTM_OFS_CTRL1) begin
            ctrl1_r <= ctm_merge(ctrl1_r, AVS_WRITEDATA[7:0],
               AVS_BYTEENABLE[0]);
         end else if (AVS_ADDRESS == `CTM_OFS_CMPA) begin
            cmpa_r[7:0] <= ctm_merge(cmpa_r[7:0],
               AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
            if (AVS_BYTEENABLE[1]) begin
               cmpa_r[9:8] <= AVS_WRITEDATA[9:8];
            end
         end else if (AVS_ADDRESS == `CTM_OFS_PRESC) begin
            presc_r <= ctm_merge(presc_r, AVS_WRITEDATA[7:0],
               AVS_BYTEENABLE[0]);
         end
      end
   end

   // ****************************************
   // timer clock tick
   // ****************************************
   logic [PRESC_W-1:0] presc_cnt_r; // divider count
   logic presc_hit; // divider wraps this cycle
   logic tick; // counter advances this cycle
   logic run_d_r; // run bit one cycle ago
   logic run_rise; // run went low to high

   assign presc_hit = (presc_cnt_r == presc_r[PRESC_W-1:0]);

   // divider runs freely; tick every presc_r+1 cycles
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         presc_cnt_r <= '0;
      end else if (presc_hit) begin
         presc_cnt_r <= '0;
      end else begin
         presc_cnt_r <= presc_cnt_r + 1'b1;
      end
   end

   // R23 - pause gates tick
   assign tick = presc_hit & counter_run & ~counter_pause;

   // run edge detector
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= counter_run;
      end
   end

   assign run_rise = counter_run & ~run_d_r;

   // ****************************************
   // comparators
   // ****************************************
   logic [10:0] inc; // counter plus one, with carry
   logic [10:0] per_span; // period comparator target
   logic a_hit; // comparator A reached
   logic p_hit; // comparator P reached
   logic ovf; // counter passes 3FF
   logic clr; // clear the counter this tick
   logic a_ev; // raise compare_a_flag
   logic p_ev; // raise period_match_flag
   logic [10:0] duty; // pwm active length
   logic pwm_act; // pwm in its active phase

   assign inc = {1'b0, cnt_r} + `CTM_CNT_ONE;
   // R13 - code zero spans 1024
   // R21 - code against bits 9..7
   assign per_span = (period_compare_value == 3'h0) ?
      `CTM_FULL_SPAN : {1'b0, period_compare_value, `CTM_PER_LSB};
   assign p_hit = (inc == per_span);
   // R5 - zero value never matches
   assign a_hit = (cmpa_r != `CTM_RST_CMPA) &&
      (inc == {1'b0, cmpa_r});
   assign ovf = (inc == `CTM_FULL_SPAN);

   // clear source and flag selection per mode
   always_comb begin
      clr = 1'b0;
      a_ev = 1'b0;
      p_ev = 1'b0;
      if (mode == CTM_MODE_PWM) begin
         // R11 - clear_select unused
         // R16 - both flags raised
         a_ev = tick & a_hit;
         p_ev = tick & p_hit;
         if (!period_duty_swap) begin
            // R12 - period match clears
            clr = p_hit;
         end else begin
            // R14 - compare-A clears
            clr = a_hit | ovf;
         end
      end else if (!clear_select) begin
         // R2 - period or overflow
         clr = p_hit;
         // R3 - both flags raised
         a_ev = tick & a_hit;
         p_ev = tick & p_hit;
      end else begin
         // R4 - compare-A clears, A flag only
         // R5 - overflow at 3FF
         clr = a_hit | ovf;
         a_ev = tick & a_hit;
      end
   end

   // ****************************************
   // counter
   // ****************************************
   // R20 - rise zeroes, fall holds
   // R24 - count and wrap
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cnt_r <= `CTM_RST_CNT;
      end else if (run_rise) begin
         cnt_r <= `CTM_RST_CNT;
      end else if (tick) begin
         cnt_r <= clr ? `CTM_RST_CNT : inc[9:0];
      end
   end

   // ****************************************
   // match flags
   // ****************************************
   logic [1:0] flag_clr; // write-one-to-clear bits
   logic [1:0] flag_set; // hardware events

   assign flag_clr = (wr_go && AVS_ADDRESS == `CTM_OFS_FLAGS &&
      AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[1:0] : 2'h0;
   assign flag_set[`CTM_FL_A] = a_ev;
   assign flag_set[`CTM_FL_P] = p_ev;

   // a set in the clearing cycle wins so no event is lost
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         flag_r <= `CTM_RST_FLAGS;
      end else begin
         flag_r <= flag_set | (flag_r & ~flag_clr);
      end
   end

   assign COMPARE_A_FLAG = flag_r[`CTM_FL_A];
   assign PERIOD_MATCH_FLAG = flag_r[`CTM_FL_P];

   // ****************************************
   // compare-match pin state
   // ****************************************
   logic pin_r; // pin level before inversion

   // R6 - moves only on A flag
   // R8 - initial level on run rise
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         pin_r <= 1'b0;
      end else if (run_rise) begin
         pin_r <= output_initial_level;
      end else if (a_ev) begin
         // R7 - action on match
         // R22 - action encoding
         case (ctm_cmp_act_e'(output_action))
            CTM_ACT_LOW: begin
               pin_r <= 1'b0;
            end
            CTM_ACT_HIGH: begin
               pin_r <= 1'b1;
            end
            CTM_ACT_TOGGLE: begin
               pin_r <= ~pin_r;
            end
            default: begin
               // no change
               pin_r <= pin_r;
            end
         endcase
      end
   end

   // ****************************************
   // pwm waveform
   // ****************************************
   // R12 - compare-A sets duty
   // R14 - period code sets duty
   assign duty = period_duty_swap ? per_span : {1'b0, cmpa_r};
   // R15 - counter always below duty
   assign pwm_act = ({1'b0, cnt_r} < duty);

   logic pwm_lvl; // pwm pin level before inversion

   // R17 - polarity and forced levels
   // R19 - counting never stops here
   always_comb begin
      case (ctm_pwm_act_e'(output_action))
         CTM_PWM_ACTIVE: begin
            pwm_lvl = output_initial_level;
         end
         CTM_PWM_RUN: begin
            pwm_lvl = pwm_act ? output_initial_level :
               ~output_initial_level;
         end
         default: begin
            // inactive; the undefined code parks here too
            pwm_lvl = ~output_initial_level;
         end
      endcase
   end

   // ****************************************
   // output pin
   // ****************************************
   logic out_r; // registered pin level
   logic oe_r; // registered pin enable

   // one register stage hides comparator glitches
   always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         out_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (mode == CTM_MODE_PWM) begin
         // R10 - pwm drives the pin
         // R18 - polarity inverts
         out_r <= pwm_lvl ^ output_invert;
         oe_r <= 1'b1;
      end else if (mode == CTM_MODE_CMP) begin
         // R18 - invert applies too
         out_r <= pin_r ^ output_invert;
         oe_r <= 1'b1;
      end else begin
         // R9 - pin released to others
         out_r <= 1'b0;
         oe_r <= 1'b0;
      end
   end

   assign TIMER_OUT = out_r;
   assign TIMER_OUT_EN = oe_r;

endmodule

// ### sim/ctm_pin_model.sv
`timescale 1ns/1ps

// ******
// load on the timer pin: counts cycles at high level
// ******
module ctm_pin_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic pin_en,
   input wire logic meas_clr,
   input wire logic meas_en,
   output logic [15:0] high_cnt
);
   logic line; // level on the board wire

   // pull-down holds the wire low once the timer lets go of it
   assign line = pin_en ? pin : 1'b0;

   // high-time counter, cleared before each window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_cnt <= 16'h0000;
      end else if (meas_clr) begin
         high_cnt <= 16'h0000;
      end else if (meas_en && line) begin
         high_cnt <= high_cnt + 16'h0001;
      end
   end
endmodule

// ### sim/ctm_timer_chk.sv
`timescale 1ns/1ps
`include "ctm_defines.svh"

// ******
// port checker, shadows the control writes from the bus
// ******
module ctm_timer_chk
   import ctm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic AVS_WAITREQUEST,
   input wire logic TIMER_OUT,
   input wire logic TIMER_OUT_EN,
   input wire logic COMPARE_A_FLAG,
   input wire logic PERIOD_MATCH_FLAG
);
   logic [7:0] c0_r; // shadow control zero
   logic [7:0] c1_r; // shadow control one
   logic [9:0] cmpa_r; // shadow compare-A
   logic [3:0] age_r; // cycles since a config write
   logic wr_ok, clr_a, run_up, stab, lvl;
   logic [10:0] per_w; // period in ticks from the code

   assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   assign clr_a = wr_ok && AVS_ADDRESS == `CTM_OFS_FLAGS && AVS_WRITEDATA[0];
   assign run_up = wr_ok && AVS_ADDRESS == `CTM_OFS_CTRL0 &&
      AVS_WRITEDATA[3] && !c0_r[3];
   // margin covers reset flops and the pin register
   assign stab = age_r >= 4'h6;
   assign lvl = c1_r[3] ^ c1_r[2];
   assign per_w = (c0_r[2:0] == 3'h0) ? 11'h400 : {1'b0, c0_r[2:0], 7'h00};

   // shadow registers and settle counter
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         c0_r <= 8'h00;
         c1_r <= 8'h00;
         cmpa_r <= 10'h000;
         age_r <= 4'h0;
      end else begin
         if (wr_ok && AVS_ADDRESS == `CTM_OFS_CTRL0) c0_r <= AVS_WRITEDATA[7:0];
         if (wr_ok && AVS_ADDRESS == `CTM_OFS_CTRL1) c1_r <= AVS_WRITEDATA[7:0];
         if (wr_ok && AVS_ADDRESS == `CTM_OFS_CMPA) cmpa_r <= AVS_WRITEDATA[9:0];
         if (wr_ok && AVS_ADDRESS <= `CTM_OFS_CMPA) age_r <= 4'h0;
         else if (age_r != 4'hF) age_r <= age_r + 4'h1;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   a_req_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("request not answered next cycle");
   a_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low longer than one cycle");
   a_pin_enable: assert property (
      stab |-> TIMER_OUT_EN == !c1_r[6]) else $error("pin enable wrong");
   a_no_p_flag: assert property (
      stab && c1_r[7:6] != 2'h2 && c1_r[0] |-> !$rose(PERIOD_MATCH_FLAG))
      else $error("period flag raised with clear on A");
   a_pin_on_a: assert property (
      stab && c1_r[7:6] == 2'h0 && $changed(TIMER_OUT)
      |-> $past(COMPARE_A_FLAG)) else $error("pin moved without A flag");
   a_run_init: assert property (
      run_up && c1_r[7:6] == 2'h0 |-> ##5 TIMER_OUT == lvl)
      else $error("pin not at initial level after run");
   a_pwm_force: assert property (
      stab && c1_r[7:6] == 2'h2 && !c1_r[5] |-> TIMER_OUT == (lvl ^ !c1_r[4]))
      else $error("forced pwm level wrong");
   a_pwm_full: assert property (
      stab && c1_r[7:6] == 2'h2 && c1_r[5:4] == 2'h2 && !c1_r[1] && c0_r[3]
      && {1'b0, cmpa_r} >= per_w |-> TIMER_OUT == lvl)
      else $error("full duty not held");
   a_flag_clear: assert property ($fell(COMPARE_A_FLAG) |-> $past(clr_a))
      else $error("A flag dropped without clear");

   c_run_up: cover property (run_up && c1_r[7:6] == 2'h0);
   c_force: cover property (stab && c1_r[7:6] == 2'h2 && !c1_r[5]);
   c_full: cover property (stab && c1_r[7:6] == 2'h2 && cmpa_r[9]);
endmodule

bind ctm_timer ctm_timer_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .TIMER_OUT(TIMER_OUT),
   .TIMER_OUT_EN(TIMER_OUT_EN), .COMPARE_A_FLAG(COMPARE_A_FLAG),
   .PERIOD_MATCH_FLAG(PERIOD_MATCH_FLAG));

// ### sim/test_compact_timer_modes.sv
`timescale 1ns/1ps
`include "ctm_defines.svh"

module test_compact_timer_modes
   import ctm_pkg::*;
;
   localparam int WIN = 3072; // whole number of every tested period
   logic clk_sys, reset_n, avs_read, avs_write, meas_en, meas_clr;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic avs_waitrequest, timer_out, timer_out_en, flag_a, flag_p;
   logic [15:0] high_cnt;
   int err_total, n_compared;

   ctm_timer u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .TIMER_OUT(timer_out), .TIMER_OUT_EN(timer_out_en),
      .COMPARE_A_FLAG(flag_a), .PERIOD_MATCH_FLAG(flag_p));

   ctm_pin_model u_load (.clk(clk_sys), .rst_n(reset_n), .pin(timer_out),
      .pin_en(timer_out_en), .meas_clr(meas_clr), .meas_en(meas_en),
      .high_cnt(high_cnt));

   // ******
   // shared tasks
   // ******
   task automatic final_report();
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // one bus access; holds until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
         input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // spare edge so the next access never reuses this time step
      @(posedge clk_sys);
   endtask

   // stop, clear flags, load compare-A and mode, start
   task automatic cfg(input logic [7:0] c1, input logic [9:0] a,
         input logic [7:0] c0);
      bus(1'b1, `CTM_OFS_CTRL0, 32'h0);
      bus(1'b1, `CTM_OFS_FLAGS, 32'h3);
      bus(1'b1, `CTM_OFS_CMPA, {22'h0, a});
      bus(1'b1, `CTM_OFS_CTRL1, {24'h0, c1});
      bus(1'b1, `CTM_OFS_CTRL0, {24'h0, c0});
   endtask

   // bounded wait for a flag, returns edges waited
   task automatic wait_flag(input logic p, output int n);
      n = 0;
      while ((p ? flag_p : flag_a) !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   // high cycles over one window from the mode fields
   function automatic int exp_high(logic [7:0] c1, logic [9:0] a,
         logic [2:0] p);
      int per, duty, h;
      per = (p == 3'h0) ? 1024 : p * 128;
      duty = a;
      if (c1[1]) begin
         duty = per;
         per = (a == 10'h000) ? 1024 : a;
      end
      h = (duty >= per) ? WIN : WIN / per * duty;
      if (c1[5:4] == 2'h0) h = 0;
      if (c1[5:4] == 2'h1) h = WIN;
      if (!c1[3]) h = WIN - h;
      if (c1[2]) h = WIN - h;
      return h;
   endfunction

   // ******
   // scenarios
   // ******
   task automatic t_regs();
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 5'(i * 4), 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, 5'h18, 32'hFF);
      bus(1'b0, 5'h18, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `CTM_OFS_COUNT, 32'h3FF);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `CTM_OFS_CTRL1, 32'hA5);
      bus(1'b0, `CTM_OFS_CTRL1, 32'h0);
      chk(rd, 32'hA5);
   endtask

   task automatic t_cmp();
      int n;
      cfg(8'h30, 10'h040, 8'h09);
      chk_b(timer_out_en, 1'b1);
      wait_flag(1'b0, n);
      wait_flag(1'b1, n);
      chk(n, 64);
      chk_b(timer_out, 1'b1);
      chk_b(flag_a & flag_p, 1'b1);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk_b(rd[9:0] < 10'h080, 1'b1);
   endtask

   task automatic t_act();
      int n;
      logic init;
      for (int i = 0; i < 4; i++) begin
         init = (i < 2);
         cfg({2'h0, 2'(i), init, 3'h0}, 10'h020, 8'h09);
         cyc(4);
         chk_b(timer_out, init);
         wait_flag(1'b0, n);
         cyc(2);
         chk_b(timer_out, (i == 0) ? init : (i != 1));
      end
   endtask

   task automatic t_clra();
      cfg(8'h01, 10'h100, 8'h09);
      cyc(600);
      chk_b(flag_a & !flag_p, 1'b1);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk_b(rd[9:0] < 10'h100, 1'b1);
      cfg(8'h01, 10'h000, 8'h09);
      cyc(1000);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk(rd[9:6], 32'hF);
      cyc(40);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk_b(rd[9:0] < 10'h040, 1'b1);
      chk_b(flag_a, 1'b0);
   endtask

   task automatic t_tmr();
      logic [31:0] a;
      cfg(8'hC0, 10'h010, 8'h0A);
      chk_b(timer_out_en, 1'b0);
      cyc(300);
      chk_b(flag_a & flag_p, 1'b1);
      bus(1'b1, `CTM_OFS_CTRL0, 32'h8A);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      a = rd;
      cyc(20);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk(rd, a);
      bus(1'b1, `CTM_OFS_CTRL0, 32'h0A);
      cyc(10);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk_b(rd - a > 8 && rd - a < 24, 1'b1);
      bus(1'b1, `CTM_OFS_CTRL0, 32'h02);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      a = rd;
      cyc(20);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk(rd, a);
      bus(1'b1, `CTM_OFS_CTRL0, 32'h0A);
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk_b(rd[9:0] < 10'h008, 1'b1);
   endtask

   task automatic t_pwm(input logic [7:0] c1, input logic [9:0] a,
         input logic [2:0] p);
      logic fa;
      fa = (a != 10'h000) && (c1[1] || a <= ((p == 3'h0) ? 1024 : p * 128));
      cfg(c1, a, {5'h01, p});
      chk_b(timer_out_en, 1'b1);
      meas_clr <= 1'b1;
      @(posedge clk_sys);
      meas_clr <= 1'b0;
      meas_en <= 1'b1;
      cyc(WIN);
      meas_en <= 1'b0;
      @(posedge clk_sys);
      chk(high_cnt, exp_high(c1, a, p));
      chk_b(flag_p, 1'b1);
      chk_b(flag_a, fa);
   endtask

   // ******
   // clock, main sequence, watchdog
   // ******
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = !clk_sys;
   end

   initial begin
      err_total = 0;
      n_compared = 0;
      reset_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      meas_en = 1'b0;
      meas_clr = 1'b0;
      cyc(3);
      reset_n <= 1'b1;
      cyc(6);
      t_regs();
      t_cmp();
      t_act();
      t_clra();
      t_tmr();
      t_pwm(8'hA9, 10'h020, 3'h1);
      t_pwm(8'hA8, 10'h200, 3'h1);
      t_pwm(8'hAA, 10'h100, 3'h1);
      t_pwm(8'hA0, 10'h020, 3'h1);
      t_pwm(8'hAC, 10'h060, 3'h3);
      t_pwm(8'hA8, 10'h100, 3'h0);
      t_pwm(8'h88, 10'h020, 3'h1);
      t_pwm(8'h98, 10'h020, 3'h1);
      final_report();
   end

   // whole run is about 30k cycles; this is well past it
   initial begin
      #1500000;
      err_total++;
      final_report();
   end
endmodule
